// >>> include/fspd_defs.svh
// timing counts and register field positions for the safety switch pre-driver
// assumes a 250 MHz system clock
`ifndef FSPD_DEFS_SVH
`define FSPD_DEFS_SVH
`define FSPD_CLK_MHZ 250
`define FSPD_MASK_TIME_US 90
`define FSPD_MASK_CYCLES (`FSPD_MASK_TIME_US * `FSPD_CLK_MHZ)
`define FSPD_FILTER_TIME_NS 100
`define FSPD_FILTER_CYCLES ((`FSPD_FILTER_TIME_NS * `FSPD_CLK_MHZ + 999) / 1000)
`define FSPD_CFG_TH_LSB 0
`define FSPD_CFG_EN_BIT 2
`define FSPD_FLT_VDS_BIT 10
`define FSPD_PIN_INHIBIT_BIT 0
`define FSPD_PIN_ECHO_BIT 7
`define FSPD_CHANNELS 4
`define FSPD_PKG_MULTI 2'h1
`endif

// >>> include/fspd_pkg.sv
// types for the safety switch pre-driver
// no assumptions
package fspd_pkg;
    typedef enum logic [1:0] {
        fspd_off_type_s = 2'h0,
        fspd_idle_type_s = 2'h1,
        fspd_run_type_s = 2'h3
    } fspd_state_type;
    typedef struct packed {
        logic enable;
        logic [1:0] threshold;
    } fspd_cfg_type;
endpackage

// >>> logic/fspd_ctrl.sv
// safety switch pre-driver control: gating, vds monitor, fault latch, package channels
// assumes comparator and pin inputs are asynchronous; config write is a one-cycle strobe
`timescale 1ns/1ps
`include "fspd_defs.svh"
module fspd_ctrl import fspd_pkg::*; #(
    parameter int MASK_CYCLES = `FSPD_MASK_CYCLES,
    parameter int FILTER_CYCLES = `FSPD_FILTER_CYCLES,
    parameter int CHANNELS = `FSPD_CHANNELS
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // device state and nvm
    input wire logic dev_active_i,
    input wire logic nvm_done_i,
    input wire logic nvm_crc_ok_i,
    input wire logic [1:0] nvm_pkg_code_i,
    // configuration and command
    input wire logic cfg_wr_i,
    input wire logic [2:0] cfg_wdata_i,
    input wire logic gate_cmd_i,
    input wire logic fault_rd_i,
    // pins and monitors
    input wire logic driver_inhibit_pin_i,
    input wire logic [3:0] vds_over_i,
    input wire logic clk_stuck_i,
    input wire logic core_ov_i,
    // outputs
    output logic [3:0] safety_gate_out_o,
    output logic [3:0] ch_enabled_o,
    output logic [1:0] vds_threshold_o,
    output logic [2:0] safety_switch_config_reg_o,
    output logic [15:0] service_fault_reg_o,
    output logic [7:0] pin_level_reg_o,
    output logic fault_o,
    output logic [1:0] state_o
);

    if (CHANNELS != 4 || MASK_CYCLES < 1 || FILTER_CYCLES < 1) begin : g_bad_param
        $error("unsupported parameter values");
    end

    localparam int CW = $clog2(MASK_CYCLES + FILTER_CYCLES + 2);

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_reg <= 6'h0;
            sync2_reg <= 6'h0;
        end else begin
            sync1_reg <= {driver_inhibit_pin_i, vds_over_i, clk_stuck_i | core_ov_i};
            sync2_reg <= sync1_reg;
        end
    end
    logic pin_en;
    logic [3:0] vds_over;
    logic int_fault;
    assign pin_en = sync2_reg[5];
    assign vds_over = sync2_reg[4:1];
    assign int_fault = sync2_reg[0];

    ////////////////////////////////////////////////////////////////////////////
    // package channel capture
    logic [3:0] ch_en_reg, ch_en_next;
    logic pkg_done_reg, pkg_done_next;
    always_comb begin
        ch_en_next = ch_en_reg;
        pkg_done_next = pkg_done_reg;
        if (!pkg_done_reg && nvm_done_i) begin
            pkg_done_next = 1'b1;
            if (nvm_crc_ok_i && nvm_pkg_code_i == `FSPD_PKG_MULTI)
                ch_en_next = 4'hf;
            else
                ch_en_next = 4'h1;
        end
    end
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ch_en_reg <= 4'h0;
            pkg_done_reg <= 1'b0;
        end else begin
            ch_en_reg <= ch_en_next;
            pkg_done_reg <= pkg_done_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // config, fault latch and state
    fspd_cfg_type cfg_reg, cfg_next;
    logic fault_reg, fault_next;
    fspd_state_type st_reg, st_next;
    logic [3:0] trip;
    logic hw_off;
    assign hw_off = !pin_en || int_fault;
    always_comb begin
        cfg_next = cfg_reg;
        fault_next = fault_reg;
        st_next = st_reg;
        if (fault_rd_i)
            fault_next = 1'b0;
        if (|trip) begin
            fault_next = 1'b1;
            cfg_next.enable = 1'b0;
        end
        if (cfg_wr_i) begin
            cfg_next.threshold = cfg_wdata_i[`FSPD_CFG_TH_LSB +: 2];
            if (!(fault_reg || |trip))
                cfg_next.enable = cfg_wdata_i[`FSPD_CFG_EN_BIT];
        end
        unique case (st_reg)
            fspd_off_type_s: if (dev_active_i) st_next = fspd_idle_type_s;
            fspd_idle_type_s: if (cfg_next.enable && !hw_off && !fault_next)
                st_next = fspd_run_type_s;
            fspd_run_type_s: if (!cfg_next.enable || hw_off || fault_next)
                st_next = fspd_idle_type_s;
            default: st_next = fspd_off_type_s;
        endcase
        if (!dev_active_i) begin
            st_next = fspd_off_type_s;
            cfg_next = '0;
            fault_next = 1'b0;
        end
    end
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cfg_reg <= '0;
            fault_reg <= 1'b0;
            st_reg <= fspd_off_type_s;
        end else begin
            cfg_reg <= cfg_next;
            fault_reg <= fault_next;
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per channel gate, blanking and filter
    logic [3:0] digital_on;
    logic [3:0] gate_reg;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ch
            logic [CW-1:0] cnt_reg, cnt_next;
            logic trip_c;
            assign digital_on[g] = (st_reg == fspd_run_type_s) && gate_cmd_i
                && ch_en_reg[g];
            always_comb begin
                cnt_next = cnt_reg;
                trip_c = 1'b0;
                if (!gate_reg[g]) begin
                    cnt_next = '0;
                end else if (cnt_reg < CW'(MASK_CYCLES)) begin
                    cnt_next = cnt_reg + 1'b1;
                end else if (!vds_over[g]) begin
                    cnt_next = CW'(MASK_CYCLES);
                end else if (cnt_reg < CW'(MASK_CYCLES + FILTER_CYCLES - 1)) begin
                    cnt_next = cnt_reg + 1'b1;
                end else begin
                    trip_c = 1'b1;
                    cnt_next = CW'(MASK_CYCLES);
                end
            end
            assign trip[g] = trip_c;
            always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
                if (sys_rst_i)
                    cnt_reg <= '0;
                else
                    cnt_reg <= cnt_next;
            end
        end
    endgenerate

    logic [3:0] gate_next;
    always_comb begin
        gate_next = digital_on & ~{4{|trip}};
        if (hw_off)
            gate_next = 4'h0;
    end
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            gate_reg <= 4'h0;
        else
            gate_reg <= gate_next;
    end

    logic echo_reg, echo_next;
    always_comb begin
        echo_next = hw_off && cfg_reg.enable;
    end
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            echo_reg <= 1'b0;
        else
            echo_reg <= echo_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign safety_gate_out_o = gate_reg & ~{4{hw_off}};
    assign ch_enabled_o = ch_en_reg;
    assign vds_threshold_o = cfg_reg.threshold;
    assign safety_switch_config_reg_o = {cfg_reg.enable, cfg_reg.threshold};
    assign service_fault_reg_o = 16'(fault_reg) << `FSPD_FLT_VDS_BIT;
    assign pin_level_reg_o = {echo_reg, 6'h0, pin_en};
    assign fault_o = fault_reg;
    assign state_o = st_reg;

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    // checker helper: cycles that gate 0 has stood high, saturating
    logic [CW-1:0] on_cnt_reg, on_cnt_next;
    always_comb begin
        on_cnt_next = '0;
        if (gate_reg[0] && on_cnt_reg != '1)
            on_cnt_next = on_cnt_reg + 1'b1;
        else if (gate_reg[0])
            on_cnt_next = on_cnt_reg;
    end
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            on_cnt_reg <= '0;
        else
            on_cnt_reg <= on_cnt_next;
    end

    property p_gate_needs_en;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        |safety_gate_out_o |-> $past(cfg_reg.enable);
    endproperty
    a_gate_needs_en: assert property (p_gate_needs_en) else $error("gate without enable");

    property p_thr;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        cfg_wr_i && dev_active_i |=> vds_threshold_o == $past(cfg_wdata_i[1:0]);
    endproperty
    a_thr: assert property (p_thr) else $error("threshold not taken");

    property p_blank;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        trip[0] |-> on_cnt_reg >= CW'(MASK_CYCLES + FILTER_CYCLES - 1);
    endproperty
    a_blank: assert property (p_blank) else $error("trip in blanking");

    property p_trip;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        |trip && dev_active_i |=> fault_reg && gate_reg == 4'h0;
    endproperty
    a_trip: assert property (p_trip) else $error("trip did not latch");

    property p_hold;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        fault_reg && !fault_rd_i && dev_active_i |=> fault_reg;
    endproperty
    a_hold: assert property (p_hold) else $error("fault lost");

    property p_inhibit;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        fault_reg |-> !cfg_reg.enable;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("enable during fault");

    property p_pin;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !pin_en |-> safety_gate_out_o == 4'h0;
    endproperty
    a_pin: assert property (p_pin) else $error("gate with pin low");

    property p_run_gate;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        st_reg == fspd_run_type_s && gate_cmd_i && !(|trip) && !hw_off
            |=> gate_reg == $past(ch_en_reg);
    endproperty
    a_run_gate: assert property (p_run_gate) else $error("gate not following command");

    property p_setwins;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        fault_rd_i && |trip && dev_active_i |=> fault_reg;
    endproperty
    a_setwins: assert property (p_setwins) else $error("clear beat set");

    property p_off;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !dev_active_i |=> safety_switch_config_reg_o == 3'h0 && !fault_reg;
    endproperty
    a_off: assert property (p_off) else $error("off state not default");

endmodule // fspd_ctrl

// >>> sim/fspd_fet_model.sv
// model of the external safety fets and their drain-source comparators
// assumes one gate per channel; short_i pretends a load short on every channel
`timescale 1ns/1ps
module fspd_fet_model (
    // clock
    input wire logic clk_sys_i,
    // gate and fault stimulus
    input wire logic [3:0] gate_i,
    input wire logic short_i,
    // comparator outputs
    output logic [3:0] vds_over_o
);
    logic [3:0] on_reg;
    ////////////////////////////////////////////////////////////////////////////
    // fet conducts one cycle after its gate rises; an off or shorted fet shows high vds
    always_ff @(posedge clk_sys_i) begin
        on_reg <= gate_i;
    end
    assign vds_over_o = ~on_reg | {4{short_i}};
endmodule // fspd_fet_model

// >>> sim/test_fspd_ctrl.sv
// self-checking bench for the safety switch pre-driver control
// assumes the fet model in fspd_fet_model and short sim counts 8 and 3
`timescale 1ns/1ps
module test_fspd_ctrl import fspd_pkg::*;;
    logic clk, rst, act, done, crc, wr, cmd, rd, pin, stuck, ov, shrt;
    logic [1:0] pkg, thr, st;
    logic [2:0] wd, cfg;
    logic [3:0] vds, gate, chen;
    logic [15:0] flt;
    logic [7:0] pins;
    logic fault;
    int failures = 0;
    int checks_done = 0;
    int i;
    // each row: config write data, then the threshold that it must select
    logic [4:0] rows [4] = '{5'h00, 5'h05, 5'h0a, 5'h0f};
    ////////////////////////////////////////////////////////////////////////////
    fspd_ctrl #(.MASK_CYCLES(8), .FILTER_CYCLES(3), .CHANNELS(4)) u_fspd_ctrl (
        .clk_sys_i(clk), .sys_rst_i(rst), .dev_active_i(act), .nvm_done_i(done),
        .nvm_crc_ok_i(crc), .nvm_pkg_code_i(pkg), .cfg_wr_i(wr), .cfg_wdata_i(wd),
        .gate_cmd_i(cmd), .fault_rd_i(rd), .driver_inhibit_pin_i(pin),
        .vds_over_i(vds), .clk_stuck_i(stuck), .core_ov_i(ov),
        .safety_gate_out_o(gate), .ch_enabled_o(chen), .vds_threshold_o(thr),
        .safety_switch_config_reg_o(cfg), .service_fault_reg_o(flt),
        .pin_level_reg_o(pins), .fault_o(fault), .state_o(st));
    fspd_fet_model u_fspd_fet_model (.clk_sys_i(clk), .gate_i(gate), .short_i(shrt),
        .vds_over_o(vds));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cfg_write(input logic [2:0] d);
        @(posedge clk);
        wr <= 1'b1;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #40000;
        failures++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, act, crc, pkg, pin} = {1'b1, 1'b1, 1'b1, 2'h1, 1'b1};
        {done, wr, wd, cmd, rd, stuck, ov, shrt} = '0;
        cyc(6);
        rst <= 1'b0;
        done <= 1'b1;
        cyc(3);
        chk(chen, 4'hf);
        chk(st, 2'h1);
        foreach (rows[k]) begin
            cfg_write(rows[k][4:2]);
            cyc(1);
            chk(thr, rows[k][1:0]);
            chk(cfg, {1'b0, rows[k][1:0]});
        end
        chk(gate, 4'h0);
        cmd <= 1'b1;
        cfg_write(3'h5);
        cyc(4);
        chk(st, 2'h3);
        chk(gate, 4'hf);
        cmd <= 1'b0;
        cyc(2);
        chk(gate, 4'h0);
        cmd <= 1'b1;
        pin <= 1'b0;
        cyc(4);
        chk(gate, 4'h0);
        chk(pins[7], 1'b1);
        chk(pins[0], 1'b0);
        pin <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            {stuck, ov} <= k ? 2'b01 : 2'b10;
            cyc(4);
            chk(gate, 4'h0);
            {stuck, ov} <= 2'b00;
            cyc(4);
            chk(gate, 4'hf);
        end
        cmd <= 1'b0;
        cyc(3);
        shrt <= 1'b1;
        cmd <= 1'b1;
        for (i = 0; i < 10 && gate !== 4'hf; i++) cyc(1);
        for (i = 0; i < 8; i++) begin
            chk(fault, 1'b0);
            cyc(1);
        end
        cyc(2);
        chk(fault, 1'b0);
        rd <= 1'b1;
        cyc(1);
        rd <= 1'b0;
        chk(fault, 1'b1);
        for (i = 0; i < 20 && fault !== 1'b1; i++) cyc(1);
        chk(flt, 16'h0400);
        chk(gate, 4'h0);
        shrt <= 1'b0;
        cyc(5);
        chk(fault, 1'b1);
        cfg_write(3'h4);
        cyc(4);
        chk(gate, 4'h0);
        rd <= 1'b1;
        cyc(1);
        rd <= 1'b0;
        cyc(2);
        chk(flt, 16'h0000);
        chk(gate, 4'h0);
        cfg_write(3'h4);
        cyc(4);
        chk(gate, 4'hf);
        act <= 1'b0;
        cyc(3);
        chk(cfg, 3'h0);
        chk(st, 2'h0);
        act <= 1'b1;
        rst <= 1'b1;
        crc <= 1'b0;
        cyc(6);
        rst <= 1'b0;
        cyc(3);
        chk(chen, 4'h1);
        final_report();
    end
endmodule // test_fspd_ctrl
